/* File: rtl/port_pin_function_mux.sv */
`timescale 1ns/1ps
`include "pin_mux_consts.svh"

module port_pin_function_mux
    import pin_mux_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire pins_type pin_in_i,
    output pins_type pin_out_o,
    output pins_type pin_oe_o,
    input wire periph_out_type periph_out_i,
    output periph_in_type periph_in_o,
    output logic [2:0] ext_irq_o,
    output logic irq_o
);
    mux_state_type r;
    mux_state_type next_r;
    pins_type pin_s;
    logic ex0_pin;
    logic ev0;
    logic ev1;
    logic [6:0] ev12;
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [6:0] clr12;
    logic [2:0] clrst;

    // Port 1 function table, indexed by mode and pin
    function automatic p1_func_type p1_func(input logic [1:0] mode, input logic [2:0] pin);
        p1_func_type t [8];
        case (mode)
            2'b00: t = '{FN_RX, FN_TX, FN_SCL, FN_SDA, FN_SSN, FN_MOSI, FN_MISO, FN_SCK};
            2'b01: t = '{FN_SCL, FN_SDA, FN_RX, FN_TX, FN_SSN, FN_MISO, FN_MISO, FN_SCK};
            2'b10: t = '{FN_SSN, FN_MOSI, FN_MISO, FN_SCK, FN_RX, FN_TX, FN_SCL, FN_SDA};
            default: t = '{FN_SSN, FN_MOSI, FN_MISO, FN_SCK, FN_SCL, FN_SDA, FN_RX, FN_TX};
        endcase
        return t[pin];
    endfunction

    // Pin inputs cross into the clock domain
    pin_sync #(
        .WIDTH(17)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(pin_in_i),
        .q_o(pin_s)
    );

    assign ex0_pin = r.pin_cfg[`CFG_EX0_SEL] ? pin_s.p2[2] : pin_s.p2[0];

    irq_trigger u_ex0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(ex0_pin),
        .edge_i(r.trig[`TRIG_EX0]),
        .event_o(ev0)
    );

    irq_trigger u_ex1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(pin_s.p2[1]),
        .edge_i(r.trig[`TRIG_EX1]),
        .event_o(ev1)
    );

    for (genvar g = 0; g < 7; g++) begin : g_ext_irq_port_group
        irq_trigger u_trig (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .pin_i(pin_s.p1[g]),
            .edge_i(r.trig[`TRIG_EXT_IRQ_PORT_GROUP]),
            .event_o(ev12[g])
        );
    end

    // Bus decode; writes land on the acknowledging edge
    assign req = cyc_i & stb_i;
    assign wr = req & we_i & r.ack & sel_i[0];
    assign idx = adr_i[9:2];
    assign wd = dat_i[7:0];
    assign clr12 = (wr && idx == `IDX_SRC_FLAGS) ? wd[6:0] : 7'h00;
    assign clrst = (wr && idx == `IDX_IRQ_STAT) ? wd[2:0] : 3'h0;

    always_comb begin
        p1_func_type fn;
        logic en;
        logic v;
        fn = FN_RX;
        en = 1'b0;
        v = 1'b1;
        next_r = r;

        if (wr) begin
            case (idx)
                `IDX_P0_FUNC: next_r.p0_func = wd[7:2];
                `IDX_PIN_CFG: next_r.pin_cfg = wd;
                `IDX_TRIG_CFG: next_r.trig = wd[2:0];
                `IDX_DRV_A: next_r.drv_a = wd[7:2];
                `IDX_DRV_B: next_r.drv_b = wd;
                `IDX_DRV_C: next_r.drv_c = wd[6:4];
                `IDX_IRQ_MASK: next_r.mask = wd[2:0];
                `IDX_OUT_A: next_r.out_a = wd[7:2];
                `IDX_OUT_B: next_r.out_b = wd;
                `IDX_OUT_C: next_r.out_c = wd[6:4];
                default: ;
            endcase
        end

        // sticky source flags, set beats clear
        next_r.flags = (r.flags & ~clr12) | ev12;
        next_r.stat = (r.stat & ~clrst) | {|ev12, ev1, ev0};
        next_r.irq = |(next_r.stat & next_r.mask);

        // Answer one cycle after the request, drop the next
        next_r.ack = req & ~r.ack;
        if (req && !r.ack) begin
            case (idx)
                `IDX_P0_FUNC: next_r.dat = {r.p0_func, 2'b00};
                `IDX_PIN_CFG: next_r.dat = r.pin_cfg;
                `IDX_TRIG_CFG: next_r.dat = {5'h00, r.trig};
                `IDX_SRC_FLAGS: next_r.dat = {1'b0, r.flags};
                `IDX_DRV_A: next_r.dat = {r.drv_a, 2'b00};
                `IDX_DRV_B: next_r.dat = r.drv_b;
                `IDX_DRV_C: next_r.dat = {1'b0, r.drv_c, 4'h0};
                `IDX_IRQ_STAT: next_r.dat = {5'h00, r.stat};
                `IDX_IRQ_MASK: next_r.dat = {5'h00, r.mask};
                `IDX_OUT_A: next_r.dat = {r.out_a, 2'b00};
                `IDX_OUT_B: next_r.dat = r.out_b;
                `IDX_OUT_C: next_r.dat = {1'b0, r.out_c, 4'h0};
                `IDX_IN_A: next_r.dat = {pin_s.p0, 2'b00};
                `IDX_IN_B: next_r.dat = pin_s.p1;
                `IDX_IN_C: next_r.dat = {1'b0, pin_s.p2, 4'h0};
                default: next_r.dat = 8'h00;
            endcase
        end

        // select between PWM and GPIO latch
        // channel order Z,W,Y,V,X,U on pins 7..2
        next_r.pin_out.p0 = (r.p0_func & r.out_a) | (~r.p0_func & periph_out_i.pwm);

        // unrouted inputs sit at the inactive level
        next_r.per_in = '1;

        // port 1 routing, lowest pin wins a shared input
        // port 1 routing for all four modes
        for (int i = 7; i >= 0; i--) begin
            fn = p1_func(r.pin_cfg[`CFG_P1_LSB +: 2], 3'(i));
            case (fn)
                FN_RX: begin
                    en = 1'b0;
                    v = 1'b1;
                    next_r.per_in.uart_rx = pin_s.p1[i];
                end
                FN_TX: begin
                    en = 1'b1;
                    v = periph_out_i.uart_tx;
                end
                FN_SCL: begin
                    en = 1'b1;
                    v = periph_out_i.scl;
                    next_r.per_in.scl = pin_s.p1[i];
                end
                FN_SDA: begin
                    en = 1'b1;
                    v = periph_out_i.sda;
                    next_r.per_in.sda = pin_s.p1[i];
                end
                default: begin
                    en = periph_out_i.spi_oe[fn[1:0]];
                    v = periph_out_i.spi[fn[1:0]];
                    next_r.per_in.spi[fn[1:0]] = pin_s.p1[i];
                end
            endcase
            // GPIO latch gates every function output
            next_r.pin_out.p1[i] = en ? (v & r.out_b[i]) : r.out_b[i];
        end

        // port 2 compare outputs or timer inputs
        case (r.pin_cfg[`CFG_P2_LSB +: 2])
            2'b10: begin
                next_r.pin_out.p2 = r.out_c;
                next_r.per_in.counter_in = pin_s.p2;
            end
            2'b11: begin
                next_r.pin_out.p2 = r.out_c;
                next_r.per_in.counter_in[2] = pin_s.p2[0];
                next_r.per_in.counter_c_aux_in = pin_s.p2[1];
                next_r.per_in.counter_in[0] = pin_s.p2[2];
            end
            default: begin
                next_r.pin_out.p2 = periph_out_i.compare_out & r.out_c;
            end
        endcase

        // push-pull drives always, open-drain only low
        next_r.pin_oe = {r.drv_c, r.drv_b, r.drv_a} | ~next_r.pin_out;
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            // PWM on port 0, mode 00 peripheral functions on ports 1 and 2
            r.p0_func <= `RST_P0_FUNC;
            r.pin_cfg <= `RST_PIN_CFG;
            r.drv_a <= `RST_DRV_A;
            r.drv_b <= `RST_DRV_B;
            r.drv_c <= `RST_DRV_C;
            r.out_a <= `RST_OUT_A;
            r.out_b <= `RST_OUT_B;
            r.out_c <= `RST_OUT_C;
            r.per_in <= '1;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign dat_o = {24'h00_0000, r.dat};
    assign ack_o = r.ack;
    assign pin_out_o = r.pin_out;
    assign pin_oe_o = r.pin_oe;
    assign periph_in_o = r.per_in;
    assign ext_irq_o = r.stat;
    assign irq_o = r.irq;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_p0_gpio_pick: assert property (
        (ce_i && r.p0_func[0]) |=> r.pin_out.p0[0] == $past(r.out_a[0]))
        else $error("port 0 GPIO bit not driven from latch");

    chk_p0_pwm_order: assert property (
        (ce_i && !r.p0_func[5]) |=> r.pin_out.p0[5] == $past(periph_out_i.pwm.z))
        else $error("port 0 pin 7 does not carry Z channel");

    chk_reset_pwm_mode: assert property (
        $fell(rst_i) |-> (r.p0_func == `RST_P0_FUNC && r.pin_cfg == `RST_PIN_CFG))
        else $error("reset configuration wrong");

    chk_open_drain_oe: assert property (
        (ce_i && !r.drv_b[3]) |=> r.pin_oe.p1[3] == !r.pin_out.p1[3])
        else $error("open-drain pin drives high");

    chk_p1_mode0_rx: assert property (
        (ce_i && r.pin_cfg[1:0] == 2'b00) |=> r.per_in.uart_rx == $past(pin_s.p1[0]))
        else $error("mode 00 receive not from pin 0");

    chk_p1_mode3_rx: assert property (
        (ce_i && r.pin_cfg[1:0] == 2'b11) |=> r.per_in.uart_rx == $past(pin_s.p1[6]))
        else $error("mode 11 receive not from pin 6");

    chk_p2_timer_map: assert property (
        (ce_i && r.pin_cfg[3:2] == 2'b11) |=> r.per_in.counter_in[0] == $past(pin_s.p2[2]))
        else $error("mode 11 counter a not from pin 6");

    chk_ex0_level_flag: assert property (
        (ce_i && ev0) |=> r.stat[0])
        else $error("first external event lost");

    chk_src_flag_sticky: assert property (
        (ce_i && ev12[3] && !r.flags[3]) |=> r.flags[3] ##1 (r.flags[3] || $past(clr12[3])))
        else $error("source flag not set or not held");

    chk_flag_write_clear: assert property (
        (ce_i && clr12[3] && !ev12[3]) |=> !r.flags[3])
        else $error("source flag not cleared by write");

    chk_ex1_event_flag: assert property (
        (ce_i && ev1) |=> r.stat[1])
        else $error("second external event lost");

    chk_p1_latch_gate: assert property (
        (ce_i && !r.out_b[2]) |=> !r.pin_out.p1[2])
        else $error("port 1 latch low does not force pin low");

    chk_push_pull_oe: assert property (
        (ce_i && r.drv_a[0]) |=> r.pin_oe.p0[0])
        else $error("push-pull pin not driven");

    chk_p2_compare_out: assert property (
        (ce_i && r.pin_cfg[3:2] == 2'b00)
        |=> r.pin_out.p2[1] == $past(periph_out_i.compare_out[1] & r.out_c[1]))
        else $error("compare output b not on pin 5");

    chk_unrouted_idle: assert property (
        (ce_i && r.pin_cfg[1:0] == 2'b01) |=> r.per_in.spi[1])
        else $error("unrouted MOSI input not idle");

    chk_irq_from_stat: assert property (
        (r.stat[1] && r.mask[1]) |-> irq_o)
        else $error("unmasked status without interrupt");

    chk_ack_single: assert property (
        ack_o |=> !ack_o)
        else $error("acknowledge held over two cycles");

    chk_ack_answer: assert property (
        (ce_i && cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not answered next cycle");

    cov_port_group_irq: cover property (ev12 != 7'h00 ##1 irq_o);
    cov_mode_spi_first: cover property (r.pin_cfg[1:0] == 2'b10 && ack_o);
    cov_p0_gpio: cover property (r.p0_func == 6'h3f);
    cov_first_irq_edge: cover property (r.trig[0] && ev0);
    cov_p2_timer_mode: cover property (r.pin_cfg[3:2] == 2'b11 && ack_o);
endmodule

/* File: shared/pin_mux_consts.svh */
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// Register word indices, byte address is four times the index
`define IDX_P0_FUNC 8'hf8
`define IDX_PIN_CFG 8'hf9
`define IDX_TRIG_CFG 8'hfa
`define IDX_SRC_FLAGS 8'hfb
`define IDX_DRV_A 8'hfc
`define IDX_DRV_B 8'hfd
`define IDX_DRV_C 8'hfe
`define IDX_IRQ_STAT 8'hf0
`define IDX_IRQ_MASK 8'hf1
`define IDX_OUT_A 8'hf2
`define IDX_OUT_B 8'hf3
`define IDX_OUT_C 8'hf4
`define IDX_IN_A 8'hf5
`define IDX_IN_B 8'hf6
`define IDX_IN_C 8'hf7

// Field positions in pin_function_config and the trigger register
`define CFG_P1_LSB 0
`define CFG_P2_LSB 2
`define CFG_EX0_SEL 4
`define TRIG_EX0 0
`define TRIG_EX1 1
`define TRIG_EXT_IRQ_PORT_GROUP 2

// Reset values
`define RST_P0_FUNC 6'h00
`define RST_PIN_CFG 8'h00
`define RST_DRV_A 6'h3f
`define RST_DRV_B 8'h00
`define RST_DRV_C 3'h0
`define RST_OUT_A 6'h3f
`define RST_OUT_B 8'hff
`define RST_OUT_C 3'h7

`endif

/* File: shared/pin_mux_pkg.sv */
package pin_mux_pkg;

    // Pin groups: p0[0] is port 0 pin 2, p2[0] is port 2 pin 4
    typedef struct packed {
        logic [2:0] p2;
        logic [7:0] p1;
        logic [5:0] p0;
    } pins_type;

    // Motor PWM channels, ordered as port 0 pins 7 down to 2
    typedef struct packed {
        logic z;
        logic w;
        logic y;
        logic v;
        logic x;
        logic u;
    } pwm_type;

    // Drives from the on-chip peripherals; spi index = function code low bits
    typedef struct packed {
        pwm_type pwm;
        logic uart_tx;
        logic scl;
        logic sda;
        logic [3:0] spi;
        logic [3:0] spi_oe;
        logic [2:0] compare_out;
    } periph_out_type;

    // Levels delivered to the peripherals; counter_in[0] is counter a
    typedef struct packed {
        logic uart_rx;
        logic scl;
        logic sda;
        logic [3:0] spi;
        logic [2:0] counter_in;
        logic counter_c_aux_in;
    } periph_in_type;

    // Port 1 pin functions
    typedef enum logic [2:0] {
        FN_RX = 3'h0,
        FN_TX = 3'h1,
        FN_SCL = 3'h2,
        FN_SDA = 3'h3,
        FN_SSN = 3'h4,
        FN_MOSI = 3'h5,
        FN_MISO = 3'h6,
        FN_SCK = 3'h7
    } p1_func_type;

    typedef struct packed {
        logic [5:0] p0_func;
        logic [7:0] pin_cfg;
        logic [2:0] trig;
        logic [6:0] flags;
        logic [5:0] drv_a;
        logic [7:0] drv_b;
        logic [2:0] drv_c;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [5:0] out_a;
        logic [7:0] out_b;
        logic [2:0] out_c;
        logic ack;
        logic [7:0] dat;
        pins_type pin_out;
        pins_type pin_oe;
        periph_in_type per_in;
        logic irq;
    } mux_state_type;

endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps

// Two-stage synchroniser for pin levels
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_type;

    sync_state_type r;
    sync_state_type next_r;

    // Meta stage feeds only the second stage
    always_comb begin
        next_r.meta = d_i;
        next_r.sync = r.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '1;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign q_o = r.sync;
endmodule

/* File: rtl/irq_trigger.sv */
`timescale 1ns/1ps

// Low-level or falling-edge detector on a synchronised pin
module irq_trigger (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic pin_i,
    input wire logic edge_i,
    output logic event_o
);
    typedef struct packed {
        logic prev;
        logic event_q;
    } trig_state_type;

    trig_state_type r;
    trig_state_type next_r;

    // Edge mode fires once per fall, level mode every low cycle
    always_comb begin
        next_r.prev = pin_i;
        next_r.event_q = edge_i ? (r.prev & ~pin_i) : ~pin_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= 2'b10;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign event_o = r.event_q;
endmodule

/* File: tb/pin_board_model.sv */
`timescale 1ns/1ps

// Board side of the port pins: external drivers and the on-chip pulls
module pin_board_model
    import pin_mux_pkg::*;
(
    input wire pins_type pin_out_i,
    input wire pins_type pin_oe_i,
    input wire pins_type ext_en_i,
    input wire pins_type ext_val_i,
    output pins_type pin_level_o
);
    // Port 0 pulled down, all other pins pulled up
    localparam pins_type PULL = 17'h1_ffc0;

    assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i)
        | (~pin_oe_i & ~ext_en_i & PULL);
endmodule

/* File: tb/port_pin_function_mux_test.sv */
`timescale 1ns/1ps
`include "pin_mux_consts.svh"

module port_pin_function_mux_test
    import pin_mux_pkg::*;
();
    logic clk_i, rst_i, cyc, stb, we, ack;
    logic [9:0] adr;
    logic [31:0] wdat, rdat;
    logic [2:0] ext_irq;
    logic irq;
    pins_type pin_level, pin_out, pin_oe, ext_en, ext_val;
    periph_out_type pdrive;
    periph_in_type pfn;
    int fail_count, comparisons;
    int tx_pin[4] = '{1, 3, 5, 7};
    int rx_pin[4] = '{0, 2, 4, 6};

    // Clock, 4 ns period
    always #2 clk_i = ~clk_i;

    port_pin_function_mux u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .pin_in_i(pin_level), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .periph_out_i(pdrive), .periph_in_o(pfn), .ext_irq_o(ext_irq), .irq_o(irq));

    pin_board_model u_board (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pin_level_o(pin_level));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single Wishbone cycle, waits for ack without a bound, then checks its latency
    task automatic wb_cycle(input logic w, input logic [7:0] idx, input logic [7:0] d,
            output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        r = rdat;
        check_val(n, 2, "bus ack latency");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wb_cycle(1'b1, idx, d, r);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        wb_cycle(1'b0, idx, 8'h00, r);
        check_val(r, exp, "register read");
    endtask

    task automatic test_reset();
        check_val(pin_out.p0, pdrive.pwm, "port0 pwm after reset");
        check_val(pin_oe.p0, 6'h3f, "port0 push-pull");
        rd(`IDX_P0_FUNC, 32'h0000_0000);
        rd(`IDX_PIN_CFG, 32'h0000_0000);
        rd(`IDX_DRV_A, 32'h0000_00fc);
        rd(8'h10, 32'h0000_0000);
        rd(`IDX_IN_A, 32'h0000_00fc);
        rd(`IDX_IN_B, 32'h0000_00ff);
        rd(`IDX_IN_C, 32'h0000_0070);
        $display("test reset done");
    endtask

    task automatic test_port0();
        pdrive.pwm <= 6'h2c;
        settle(2);
        check_val(pin_out.p0, 6'h2c, "pwm channel order");
        wr(`IDX_OUT_A, 8'h54);
        wr(`IDX_P0_FUNC, 8'hfc);
        settle(2);
        check_val(pin_out.p0, 6'h15, "port0 all gpio");
        wr(`IDX_P0_FUNC, 8'h0c);
        settle(2);
        check_val(pin_out.p0, 6'h2d, "port0 mixed");
        wr(`IDX_P0_FUNC, 8'h00);
        $display("test port0 done");
    endtask

    task automatic test_port1();
        pdrive.uart_tx <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            wr(`IDX_PIN_CFG, 8'(m));
            settle(2);
            check_val(pin_out.p1, 8'(~(8'h01 << tx_pin[m])), "tx position");
            check_val(pin_oe.p1, 8'h01 << tx_pin[m], "open drain oe");
            ext_en.p1 <= 8'h01 << rx_pin[m];
            settle(5);
            check_val(pfn.uart_rx, 1'b0, "rx routed low");
            ext_en.p1 <= 8'h00;
            settle(5);
            check_val(pfn.uart_rx, 1'b1, "rx routed high");
        end
        wr(`IDX_DRV_B, 8'hff);
        settle(2);
        check_val(pin_oe.p1, 8'hff, "push-pull oe");
        wr(`IDX_DRV_B, 8'h00);
        pdrive.uart_tx <= 1'b1;
        $display("test port1 done");
    endtask

    task automatic test_port2();
        pdrive.compare_out <= 3'b010;
        wr(`IDX_PIN_CFG, 8'h00);
        settle(2);
        check_val(pin_out.p2, 3'b010, "compare mode 00");
        wr(`IDX_PIN_CFG, 8'h04);
        settle(2);
        check_val(pin_out.p2, 3'b010, "compare mode 01");
        wr(`IDX_PIN_CFG, 8'h08);
        settle(2);
        check_val(pin_out.p2, 3'b111, "timer mode out");
        ext_en.p2 <= 3'b111;
        ext_val.p2 <= 3'b001;
        settle(5);
        check_val({pfn.counter_in, pfn.counter_c_aux_in}, 4'b0011, "mode 10 in");
        wr(`IDX_PIN_CFG, 8'h0c);
        settle(5);
        check_val({pfn.counter_in, pfn.counter_c_aux_in}, 4'b1100, "mode 11 in");
        ext_en.p2 <= 3'b000;
        pdrive.compare_out <= 3'b111;
        wr(`IDX_PIN_CFG, 8'h00);
        $display("test port2 done");
    endtask

    task automatic test_irq();
        settle(6);
        wr(`IDX_IRQ_STAT, 8'h07);
        wr(`IDX_SRC_FLAGS, 8'h7f);
        wr(`IDX_IRQ_MASK, 8'h07);
        settle(2);
        check_val({ext_irq, irq}, 4'b0000, "irq idle");
        ext_val <= 17'h0_0000;
        ext_en.p2 <= 3'b010;
        settle(6);
        check_val({ext_irq, irq}, 4'b0101, "second irq level");
        wr(`IDX_IRQ_MASK, 8'h00);
        settle(2);
        check_val(irq, 1'b0, "irq masked");
        ext_en.p2 <= 3'b000;
        settle(6);
        wr(`IDX_IRQ_STAT, 8'h02);
        settle(2);
        check_val(ext_irq, 3'b000, "status cleared");
        wr(`IDX_PIN_CFG, 8'h10);
        wr(`IDX_TRIG_CFG, 8'h01);
        wr(`IDX_IRQ_MASK, 8'h07);
        ext_en.p2 <= 3'b100;
        settle(6);
        check_val({ext_irq, irq}, 4'b0011, "first irq pin6 edge");
        wr(`IDX_IRQ_STAT, 8'h01);
        settle(4);
        check_val(ext_irq, 3'b000, "edge no re-set");
        ext_en.p2 <= 3'b000;
        ext_en.p1 <= 8'h08;
        settle(6);
        check_val(ext_irq, 3'b100, "port group irq");
        rd(`IDX_SRC_FLAGS, 32'h0000_0008);
        ext_en.p1 <= 8'h00;
        settle(6);
        wr(`IDX_SRC_FLAGS, 8'h08);
        wr(`IDX_IRQ_STAT, 8'h04);
        settle(2);
        check_val({ext_irq, irq}, 4'b0000, "group cleared");
        $display("test irq done");
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // Main sequence
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 10'h000;
        wdat = 32'h0000_0000;
        ext_en = 17'h0_0000;
        ext_val = 17'h0_0000;
        pdrive = '1;
        pdrive.spi_oe = 4'h0;
        fail_count = 0;
        comparisons = 0;
        settle(8);
        rst_i <= 1'b0;
        settle(3);
        test_reset();
        test_port0();
        test_port1();
        test_port2();
        test_irq();
        tally_and_finish();
    end
endmodule
